// ### pcs_stat_counters.v
// Purpose: Prefetch cache hit, miss and abort statistics counters on APB
// Assumes: Event inputs are one-cycle pulses synchronous to pclk
// Notes: Counter contents are undefined until software writes them
//   and survive presetn; only the read register and the bus phase are reset.
//   A write in the same cycle as an event wins over the event.
//   Unmapped offsets answer with pslverr and read as zero.
//
// Behaviour
// - Count one hit for each cacheable fetch or load that hits the prefetch cache.
// - Never change hit or miss counts for an access to a non-cacheable region.
// - Count one miss for each cacheable instruction fetch that misses the cache.
// - Count one abort whenever an automatic prefetch is abandoned by a non-sequential access.
// - The hit counter is a full 32-bit field that software reads and writes.
// - The miss counter is a full 32-bit field that software reads and writes.
// - The abort counter is a full 32-bit read-write field, undefined after power-on.
`timescale 1ns/1ps
`include "pcs_defines.vh"

module pcs_stat_counters (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PCS_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Processor access events
  input wire acc_valid,
  input wire acc_fetch,
  input wire acc_load,
  input wire acc_cacheable,
  input wire acc_hit,
  input wire prefetch_abort
);

  // Counter values
  wire [`PCS_CNT_W-1:0] hit_count;
  wire [`PCS_CNT_W-1:0] miss_count;
  wire [`PCS_CNT_W-1:0] abort_count;

  // Bus qualifiers
  wire access;
  wire wr;
  wire rd_setup;

  // Bus phase, one-hot
  localparam [2:0] PH_IDLE = 3'b001;
  localparam [2:0] PH_SETUP = 3'b010;
  localparam [2:0] PH_ACCESS = 3'b100;
  reg [2:0] phase_q;
  reg [2:0] phase_d;

  // Register decode
  reg sel_hit;
  reg sel_miss;
  reg sel_abort;
  reg mapped;

  // Processor access class, one-hot
  localparam [3:0] CLS_IDLE = 4'b0001;
  localparam [3:0] CLS_FETCH = 4'b0010;
  localparam [3:0] CLS_LOAD = 4'b0100;
  localparam [3:0] CLS_STORE = 4'b1000;
  reg [3:0] acc_class;
  reg cached_access;
  reg fetch_or_load;
  reg fetch_only;

  // Counter strobes
  reg hit_event;
  reg miss_event;
  reg abort_event;
  reg load_hit;
  reg load_miss;
  reg load_abort;
  reg inc_hit;
  reg inc_miss;
  reg inc_abort;

  // Read path
  reg [31:0] rdata_sel;
  reg [31:0] rdata_d;

  assign access = psel & penable;
  // Reads are captured in the setup cycle
  assign rd_setup = psel & ~penable & ~pwrite;

  // Tracks the bus so that an access phase counts only after its own setup cycle
  always @* begin
    phase_d = PH_IDLE;
    case (phase_q)
      PH_IDLE: begin
        if (psel & ~penable) begin
          phase_d = PH_SETUP;
        end
      end
      PH_SETUP: begin
        if (psel & penable) begin
          phase_d = PH_ACCESS;
        end else if (psel) begin
          phase_d = PH_SETUP;
        end
      end
      PH_ACCESS: begin
        if (psel & ~penable) begin
          phase_d = PH_SETUP;
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // A stray penable with no setup before it must not overwrite a count
  assign wr = access & pwrite & (phase_q == PH_SETUP);

  // Only the three word offsets are mapped
  always @* begin
    sel_hit = 1'b0;
    sel_miss = 1'b0;
    sel_abort = 1'b0;
    case (paddr)
      `PCS_OFF_HIT: begin
        sel_hit = 1'b1;
      end
      `PCS_OFF_MISS: begin
        sel_miss = 1'b1;
      end
      `PCS_OFF_ABORT: begin
        sel_abort = 1'b1;
      end
      default: begin
        sel_hit = 1'b0;
      end
    endcase
    mapped = sel_hit | sel_miss | sel_abort;
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // A fetch that also claims to be a load is taken as a fetch, so it can still miss
  always @* begin
    acc_class = CLS_IDLE;
    if (acc_valid) begin
      case ({acc_fetch, acc_load})
        2'b10: begin
          acc_class = CLS_FETCH;
        end
        2'b11: begin
          acc_class = CLS_FETCH;
        end
        2'b01: begin
          acc_class = CLS_LOAD;
        end
        default: begin
          acc_class = CLS_STORE;
        end
      endcase
    end
  end

  // Shared qualifiers for the hit and miss terms
  always @* begin
    cached_access = acc_valid & acc_cacheable;
    fetch_or_load = (acc_class == CLS_FETCH) | (acc_class == CLS_LOAD);
    fetch_only = (acc_class == CLS_FETCH);
  end

  // Stores never count as hits or misses
  always @* begin
    hit_event = 1'b0;
    if (cached_access & acc_hit & fetch_or_load) begin
      hit_event = 1'b1;
    end
  end

  // Only fetches count as misses; a missing load is not counted
  always @* begin
    miss_event = 1'b0;
    if (cached_access & ~acc_hit & fetch_only) begin
      miss_event = 1'b1;
    end
  end

  // Abort cause is judged upstream; every pulse counts once
  always @* begin
    abort_event = prefetch_abort;
  end

  // Write strobes per register; an unmapped write touches nothing
  always @* begin
    load_hit = 1'b0;
    load_miss = 1'b0;
    load_abort = 1'b0;
    if (wr) begin
      case ({sel_abort, sel_miss, sel_hit})
        3'b001: begin
          load_hit = 1'b1;
        end
        3'b010: begin
          load_miss = 1'b1;
        end
        3'b100: begin
          load_abort = 1'b1;
        end
        default: begin
          load_hit = 1'b0;
        end
      endcase
    end
  end

  // Software write wins; a same-cycle event is dropped so the written value is exact
  always @* begin
    inc_hit = hit_event;
    inc_miss = miss_event;
    inc_abort = abort_event;
    if (load_hit) begin
      inc_hit = 1'b0;
    end
    if (load_miss) begin
      inc_miss = 1'b0;
    end
    if (load_abort) begin
      inc_abort = 1'b0;
    end
  end

  // Limitation: counters have no reset, so software must write them before use
  pcs_counter u_hit (
    .pclk(pclk),
    .load(load_hit),
    .load_value(pwdata),
    .inc(inc_hit),
    .count(hit_count)
  );

  pcs_counter u_miss (
    .pclk(pclk),
    .load(load_miss),
    .load_value(pwdata),
    .inc(inc_miss),
    .count(miss_count)
  );

  pcs_counter u_abort (
    .pclk(pclk),
    .load(load_abort),
    .load_value(pwdata),
    .inc(inc_abort),
    .count(abort_count)
  );

  // Word selected for a read, zero at an unmapped offset
  always @* begin
    case ({sel_abort, sel_miss, sel_hit})
      3'b001: begin
        rdata_sel = hit_count;
      end
      3'b010: begin
        rdata_sel = miss_count;
      end
      3'b100: begin
        rdata_sel = abort_count;
      end
      default: begin
        rdata_sel = `PCS_RDATA_RST;
      end
    endcase
  end

  // Read data is registered, so the value is from the setup cycle's edge
  always @* begin
    rdata_d = prdata;
    if (rd_setup) begin
      rdata_d = rdata_sel;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PCS_RDATA_RST;
    end else begin
      prdata <= rdata_d;
    end
  end

endmodule

// ### pcs_defines.vh
// Purpose: Constants for the prefetch cache statistics counters
// Assumes: APB slave with 32-bit data, word aligned registers
// Notes: Offsets are byte addresses within the block
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

`define PCS_ADDR_W 4
`define PCS_OFF_HIT 4'h0
`define PCS_OFF_MISS 4'h4
`define PCS_OFF_ABORT 4'h8
`define PCS_CNT_W 32
`define PCS_CNT_ONE 32'h00000001
`define PCS_RDATA_RST 32'h00000000

`endif

// ### pcs_counter.v
// Purpose: One 32-bit statistics counter with software load
// Assumes: Load and increment never both wanted without a defined winner
// Notes: Contents are not reset; they are undefined until written
`timescale 1ns/1ps
`include "pcs_defines.vh"

module pcs_counter (
  // Clock
  input wire pclk,
  // Control
  input wire load,
  input wire [`PCS_CNT_W-1:0] load_value,
  input wire inc,
  // State
  output wire [`PCS_CNT_W-1:0] count
);

  reg [`PCS_CNT_W-1:0] count_q;
  reg [`PCS_CNT_W-1:0] count_d;

  // Software write wins; a same-cycle event is dropped so the written value is exact
  always @* begin
    count_d = count_q;
    if (load) begin
      count_d = load_value;
    end else if (inc) begin
      count_d = count_q + `PCS_CNT_ONE;
    end
  end

  // No reset on purpose: the counter powers up undefined
  always @(posedge pclk) begin
    count_q <= count_d;
  end

  assign count = count_q;

endmodule

// ### pcs_assertions.sv
// Purpose: APB port checks
// Assumes: map 0,4,8
// Notes: counters unseen
`timescale 1ns/1ps
module pcs_chk(input wire pclk,presetn,psel,penable,pwrite,pready,pslverr,
  input wire [3:0] paddr,input wire [31:0] prdata);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc=psel&&penable;
  a_rdy_high: assert property(pready) else $error("pready low");
  a_err_map: assert property(acc|->pslverr==!(paddr inside {4'h0,4'h4,4'h8}))
    else $error("pslverr wrong");
  a_err_idle: assert property(!acc|->!pslverr) else $error("pslverr idle");
  a_rd_hold: assert property(!(psel&&!penable&&!pwrite)|=>$stable(prdata))
    else $error("prdata moved");
  a_unmap_zero: assert property(acc&&!pwrite&&pslverr|->prdata==32'h0)
    else $error("unmapped data");
  a_unmap_rd: assert property(psel&&!penable&&!pwrite&&!(paddr inside {4'h0,4'h4,4'h8})
    |=>prdata==32'h0) else $error("unmapped read not zero");
  c_wr: cover property(acc&&pwrite);
  c_rd: cover property(acc&&!pwrite&&!pslverr);
  c_err: cover property(acc&&pslverr);
endmodule
bind pcs_stat_counters pcs_chk u_chk(.*);

// ### pcs_cpu.sv
// Purpose: fetch and load path
// Assumes: one event per call
// Notes: idle low between events
`timescale 1ns/1ps
module pcs_cpu(input wire pclk,output wire acc_valid,acc_fetch,acc_load,
  acc_cacheable,acc_hit,prefetch_abort);
  reg [5:0] s=6'h0;
  assign {acc_valid,acc_fetch,acc_load,acc_cacheable,acc_hit,prefetch_abort}=s;
  task issue(input [5:0] k);
    @(posedge pclk);
    s<=k;
    @(posedge pclk);
    s<=6'h0;
  endtask
endmodule

// ### test_pcs_stat_counters.sv
// Purpose: counter bench
// Assumes: pcs_cpu partner
// Notes: counters written first
`timescale 1ns/1ps
module test_pcs_stat_counters;
  reg pclk=0,presetn=0,psel=0,penable=0,pwrite=0,e;
  reg [3:0] paddr=4'h0;
  reg [31:0] pwdata=32'h0,r;
  int n_mismatch=0,n_checks=0;
  wire pready,pslverr,acc_valid,acc_fetch,acc_load,acc_cacheable,acc_hit,prefetch_abort;
  wire [31:0] prdata;
  // Hits, misses, uncached, store, abort
  reg [5:0] ev[8]='{6'h36,6'h2E,6'h34,6'h2C,6'h32,6'h28,6'h26,6'h01};
  pcs_stat_counters DUT(.*);
  pcs_cpu cpu(.*);
  initial forever #20 pclk=~pclk;
  task apb(input w,input [3:0] a,input [31:0] d);
    @(posedge pclk);
    psel<=1; pwrite<=w; paddr<=a; pwdata<=d;
    @(posedge pclk);
    penable<=1;
    do @(posedge pclk); while (pready!==1'b1);
    r=prdata; e=pslverr; psel<=0; penable<=0;
  endtask
  task chk(input [3:0] a,input [31:0] s,x);
    n_checks++;
    if (s!==x) begin
      n_mismatch++;
      $display("unexpected at %h exp %h seen %h",a,x,s);
    end
  endtask
  task rd(input [3:0] a,input [31:0] x);
    apb(0,a,32'h0);
    chk(a,r,x);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d",n_checks,n_mismatch);
    if (n_mismatch==0&&n_checks>0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Run needs under 150 cycles
  initial begin
    repeat(400) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    repeat(6) @(posedge pclk);
    presetn<=1;
    apb(1,4'h0,32'hFFFFFFFE);
    apb(1,4'h4,32'hA5A55A5A);
    apb(1,4'h8,32'h7FFFFFFF);
    apb(1,4'hC,32'hFFFFFFFF);
    chk(4'hC,{31'h0,e},32'h1);
    rd(4'h0,32'hFFFFFFFE);
    chk(4'h0,{31'h0,e},32'h0);
    rd(4'h4,32'hA5A55A5A);
    rd(4'h8,32'h7FFFFFFF);
    foreach (ev[i]) cpu.issue(ev[i]);
    rd(4'h0,32'h0);
    rd(4'h4,32'hA5A55A5B);
    rd(4'h8,32'h80000000);
    rd(4'hC,32'h0);
    chk(4'hC,{31'h0,e},32'h1);
    // Hit event lands on the access edge of a write; the write must win
    fork
      apb(1,4'h0,32'h00000010);
      begin
        @(posedge pclk);
        cpu.issue(6'h36);
      end
    join
    rd(4'h0,32'h00000010);
    wrap_up;
  end
endmodule
